//--- shared/ecsc_params.svh
`ifndef ECSC_PARAMS_SVH
`define ECSC_PARAMS_SVH
// Configuration RAM byte offsets.
`define ECSC_REG_FORMAT1 4'h0
`define ECSC_REG_CH2_LEN 4'h2
`define ECSC_REG_CH2_CRC 4'h3
`define ECSC_REG_PROTO 4'h5
`define ECSC_REG_VALID 4'hD
`define ECSC_CFG_RESET 8'h00
// Field positions.
`define ECSC_B_REFLECT 7
`define ECSC_B_CH_EN 6
`define ECSC_B_CFG_VALID 7
`define ECSC_B_PROTECT 0
`define ECSC_B_FIXED_TMO 1
`define ECSC_B_TMO_SHORT 2
`define ECSC_B_EXTRA_ID 3
`define ECSC_B_CMD01_DIS 4
`define ECSC_B_CMD2_LOCAL 5
`define ECSC_B_LEGACY 6
`define ECSC_B_RING 7
// Control-frame register window of the configuration RAM.
`define ECSC_WIN_BASE 7'h60
`define ECSC_WIN_TOP 7'h6F
// Generator polynomials without their top bit.
`define ECSC_POLY5 16'h0005
`define ECSC_POLY6 16'h0003
`define ECSC_POLY16 16'h90D9
// Timing.
`define ECSC_CLK_NS 8
`define ECSC_TMO_LONG_NS 20000
`define ECSC_TMO_SHORT_NS 2000
`define ECSC_TICK_SKIP 2'h3
`define ECSC_TMO_MARGIN 12'h002
`endif

//--- shared/ecsc_pkg.sv
package ecsc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE = 3'b100
  } ecsc_state_e;

  typedef enum logic [1:0] {
    CTL_CMD = 2'h0,
    CTL_READ = 2'h1,
    CTL_WRITE = 2'h2
  } ecsc_ctl_e;

  typedef struct packed {
    ecsc_state_e state;
    logic [1:0] clkSync;
    logic clkPrev;
    logic [1:0] edgeCnt;
    logic [1:0] tickPh;
    logic [11:0] measCnt;
    logic [11:0] tmoCnt;
    logic [11:0] tmoLimit;
    logic [63:0] snap1;
    logic [63:0] snap2;
    logic [63:0] sh1;
    logic [63:0] sh2;
    logic [6:0] bitCnt;
    logic [1:0] seg;
    logic [15:0] crc;
    logic lineOut;
    logic [15:0][7:0] cfg;
    logic [2:0][127:0] bank;
    logic [1:0] activeBank;
    logic [1:0] readBank;
    logic [1:0][127:0] fifo;
    logic [1:0] fifoCnt;
    logic fifoWr;
    logic fifoRd;
    logic ctlLocal;
    logic ctlToHost;
    logic ctlDenied;
    logic [7:0] ctlRdData;
    logic coupler;
  } ecsc_regs_s;
endpackage

//--- tb/ecsc_line_master.sv
`timescale 1ns/100ps
// Behavioural line master: it clocks frames and records the data line.
module ecsc_line_master #(
  parameter real HALF_NS = 62.5
) (
  output logic lineClk,
  input wire logic lineData
);
  logic [191:0] seen;
  realtime lastRise;

  // The clock stands high between frames, as a real master leaves it.
  initial
  begin
    lineClk = 1'b1;
    seen = '0;
    lastRise = 0;
  end

  // Each bit is taken half a period after its rising edge, well after it settles.
  task automatic run_frame(input int nBits);
    seen = '0;
    lineClk = 1'b0;
    for (int i = 0; i < nBits; i++)
    begin
      #(HALF_NS) lineClk = 1'b1;
      lastRise = $realtime;
      #(HALF_NS) seen[i] = lineData;
      if (i < nBits - 1)
        lineClk = 1'b0;
    end
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
`include "ecsc_params.svh"
module tb_top;
  typedef struct {
    logic [7:0] b0, b2, b3, b5;
    logic [63:0] d1, d2;
    int n;
    real tMin, tMax;
  } ecsc_row_s;
  typedef struct {
    logic [7:0] b0, b2, b5, bd;
    logic [1:0] id;
    logic [2:0] ans;
  } ecsc_id_s;
  logic mclk, rst_b, cfgWrite, sensorDataWriteCmd, ctlReq, lineClockIn;
  logic lineDataOut, sensorDataReady, ctlLocal, ctlToHost, ctlDenied, couplerOut, frameActive;
  logic [3:0] cfgAddr, ctlCmd;
  logic [7:0] cfgWdata, ctlWdata, ctlRdData;
  logic [63:0] sensorCh1, sensorCh2;
  logic [1:0] ctlKind, ctlSlaveId, activeBank, expBank;
  logic [6:0] ctlAddr;
  int errCount, samplesChecked;
  ecsc_row_s rows[5];
  ecsc_id_s ids[11];
  logic [6:0] hostAddr[7];

  ecsc_serial_slave u_dut (.mclk(mclk), .rst_b(rst_b), .lineClockIn(lineClockIn),
    .lineDataOut(lineDataOut), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
    .sensorDataWriteCmd(sensorDataWriteCmd), .sensorDataReady(sensorDataReady),
    .sensorCh1(sensorCh1), .sensorCh2(sensorCh2), .ctlReq(ctlReq), .ctlKind(ctlKind),
    .ctlSlaveId(ctlSlaveId), .ctlCmd(ctlCmd), .ctlAddr(ctlAddr), .ctlWdata(ctlWdata),
    .ctlLocal(ctlLocal), .ctlToHost(ctlToHost), .ctlDenied(ctlDenied), .ctlRdData(ctlRdData),
    .couplerOut(couplerOut), .activeBank(activeBank), .frameActive(frameActive));
  ecsc_line_master u_master (.lineClk(lineClockIn), .lineData(lineDataOut));

  // Free-running system clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compare tasks, one for each kind of result.
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkBits(input string n, input logic [191:0] e, input logic [191:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkTime(input string n, input real t, input real lo, input real hi);
    samplesChecked++;
    if (t < lo || t > hi)
    begin
      errCount++;
      $display("Error %s expected %f to %f seen %f", n, lo, hi, t);
    end
  endtask

  task automatic giveVerdict();
    if (errCount == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A wait that runs out counts as a mismatch and ends the run.
  task automatic wait_fa(input logic lvl);
    int i;
    for (i = 0; i < 4000 && frameActive !== lvl; i++)
      @(negedge mclk);
    if (i == 4000)
    begin
      errCount++;
      $display("Error frameActive expected %b seen timeout", lvl);
      giveVerdict();
    end
  endtask

  task automatic cfg_wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgWdata = d;
    @(negedge mclk);
    cfgWrite = 1'b0;
  endtask

  task automatic cfg_set(input logic [7:0] b0, b2, b5, bd);
    cfg_wr(`ECSC_REG_FORMAT1, b0);
    cfg_wr(`ECSC_REG_CH2_LEN, b2);
    cfg_wr(`ECSC_REG_PROTO, b5);
    cfg_wr(`ECSC_REG_VALID, bd);
  endtask

  // The write is held until the buffer shows room, and is taken on the next edge.
  task automatic sens_wr(input logic [63:0] a, input logic [63:0] b);
    @(negedge mclk);
    sensorDataWriteCmd = 1'b1;
    sensorCh1 = a;
    sensorCh2 = b;
    for (int i = 0; sensorDataReady !== 1'b1; i++)
    begin
      if (i == 100)
      begin
        errCount++;
        $display("Error sensorDataReady expected 1 seen timeout");
        giveVerdict();
      end
      @(negedge mclk);
    end
    @(negedge mclk);
    sensorDataWriteCmd = 1'b0;
  endtask

  // One control request; the registered answer is looked at one cycle on.
  task automatic ask(input logic [1:0] k, id, input logic [3:0] c, input logic [6:0] a,
    input logic [7:0] wd, input logic [2:0] e);
    @(negedge mclk);
    ctlReq = 1'b1;
    ctlKind = k;
    ctlSlaveId = id;
    ctlCmd = c;
    ctlAddr = a;
    ctlWdata = wd;
    @(negedge mclk);
    ctlReq = 1'b0;
    chk8("ctlAnswer", {5'h0, e}, {5'h0, ctlLocal, ctlToHost, ctlDenied});
  endtask

  task automatic reset_check();
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (8) @(negedge mclk);
    chk8("resetOuts", 8'h30, {2'h0, lineDataOut, sensorDataReady, couplerOut, frameActive,
      activeBank});
    chk8("ctlRdData", 8'h00, ctlRdData);
    rst_b = 1'b1;
    expBank = 2'h0;
  endtask

  // Expected line bits: channel one (optionally reflected), channel two, then its CRC.
  function automatic logic [191:0] expect_bits(input ecsc_row_s r);
    logic [191:0] s;
    logic [63:0] c1;
    logic [15:0] crc, poly;
    logic fb;
    int l1, l2, w, k;
    s = '0;
    k = 0;
    l1 = r.b0[5:0] + 1;
    l2 = r.b2[6] ? r.b2[5:0] + 1 : 0;
    c1 = r.b0[7] ? r.d1 ^ (r.d1 >> 1) : r.d1;
    w = r.b3[1:0] == 2'h0 ? 0 : r.b3[1:0] == 2'h1 ? 5 : r.b3[1:0] == 2'h2 ? 6 : 16;
    poly = r.b3[1:0] == 2'h1 ? `ECSC_POLY5 : r.b3[1:0] == 2'h2 ? `ECSC_POLY6 : `ECSC_POLY16;
    do
    begin
      crc = {10'h0, r.b3[7:2]};
      for (int i = l1 - 1; i >= 0 && k < r.n; i--)
        s[k++] = c1[i];
      for (int i = l2 - 1; i >= 0 && k < r.n; i--)
      begin
        s[k++] = r.d2[i];
        fb = w > 0 ? crc[w - 1] ^ r.d2[i] : 1'b0;
        crc = (crc << 1) & 16'((32'h1 << w) - 1);
        if (fb)
          crc = crc ^ poly;
      end
      for (int i = w - 1; i >= 0 && k < r.n; i--)
        s[k++] = crc[i];
    end
    while (r.b5[7] && k < r.n);
    return s;
  endfunction

  // Main sequence: reset, frame table, control table, then the awkward cases.
  initial
  begin
    rst_b = 1'b0;
    {cfgWrite, sensorDataWriteCmd, ctlReq} = 3'h0;
    {cfgAddr, cfgWdata, ctlCmd, ctlWdata, ctlKind, ctlSlaveId, ctlAddr} = '0;
    {sensorCh1, sensorCh2} = '0;
    {errCount, samplesChecked} = 0;
    rows[0] = '{8'h47, 8'h43, 8'h01, 8'h06, 64'hA5, 64'h9, 19, 1900.0, 2100.0};
    rows[1] = '{8'hC7, 8'h00, 8'h00, 8'h02, 64'h6C, 64'h0, 10, 19000.0, 21000.0};
    rows[2] = '{8'h7F, 8'h7F, 8'hAA, 8'h00, 64'hF0E1D2C3B4A59687, 64'h0123456789ABCDEF, 136,
      187.5, 260.0};
    rows[3] = '{8'h40, 8'h40, 8'hFF, 8'h06, 64'h1, 64'h1, 20, 1900.0, 2100.0};
    rows[4] = '{8'h43, 8'h40, 8'h00, 8'h86, 64'hB, 64'h1, 12, 1900.0, 2100.0};
    ids = '{'{8'h47, 8'h00, 8'h00, 8'h80, 2'h0, 3'h2}, '{8'h47, 8'h00, 8'h00, 8'h80, 2'h1, 3'h0},
      '{8'h47, 8'h00, 8'h08, 8'h80, 2'h1, 3'h2}, '{8'h47, 8'h00, 8'h08, 8'h80, 2'h2, 3'h0},
      '{8'h47, 8'h40, 8'h08, 8'h80, 2'h2, 3'h2}, '{8'h47, 8'h40, 8'h08, 8'h80, 2'h3, 3'h0},
      '{8'h07, 8'h00, 8'h08, 8'h80, 2'h0, 3'h2}, '{8'h07, 8'h00, 8'h08, 8'h80, 2'h1, 3'h0},
      '{8'h07, 8'h00, 8'h00, 8'h80, 2'h0, 3'h0}, '{8'h47, 8'h40, 8'h48, 8'h80, 2'h3, 3'h2},
      '{8'h47, 8'h00, 8'h00, 8'h00, 2'h3, 3'h2}};
    hostAddr = '{7'h00, 7'h3F, 7'h40, 7'h5F, 7'h70, 7'h78, 7'h7E};
    reset_check();
    u_master.run_frame(4);
    chkBits("invalidLine", 192'hF, u_master.seen);
    chk8("frameActive", 8'h00, {7'h0, frameActive});
    // Host stores the data before each frame, as legacy framing demands.
    foreach (rows[i])
    begin
      cfg_set(rows[i].b0, rows[i].b2, rows[i].b5, 8'h80);
      cfg_wr(`ECSC_REG_CH2_CRC, rows[i].b3);
      sens_wr(rows[i].d1, rows[i].d2);
      repeat (4) @(negedge mclk);
      expBank = expBank == 2'h2 ? 2'h0 : expBank + 2'h1;
      chk8("activeBank", {6'h0, expBank}, {6'h0, activeBank});
      u_master.run_frame(rows[i].n);
      chkBits("lineBits", expect_bits(rows[i]), u_master.seen);
      wait_fa(1'b0);
      chkTime("timeout", $realtime - u_master.lastRise,
        rows[i].tMin, rows[i].tMax);
    end
    foreach (ids[i])
    begin
      cfg_set(ids[i].b0, ids[i].b2, ids[i].b5, ids[i].bd);
      ask(2'h0, ids[i].id, 4'h3, 7'h00, 8'h00, ids[i].ans);
    end
    cfg_set(8'h47, 8'h00, 8'h00, 8'h80);
    cfg_wr(`ECSC_REG_CH2_CRC, 8'h5C);
    ask(2'h1, 2'h0, 4'h0, 7'h63, 8'h00, 3'h4);
    chk8("ctlRdData", 8'h5C, ctlRdData);
    ask(2'h2, 2'h0, 4'h0, 7'h63, 8'h77, 3'h4);
    ask(2'h1, 2'h0, 4'h0, 7'h63, 8'h00, 3'h4);
    chk8("ctlRdData", 8'h77, ctlRdData);
    ask(2'h1, 2'h0, 4'h0, 7'h6F, 8'h00, 3'h4);
    foreach (hostAddr[j])
      ask(2'h1, 2'h0, 4'h0, hostAddr[j], 8'h00, 3'h2);
    ask(2'h0, 2'h0, 4'h0, 7'h00, 8'h00, 3'h4);
    ask(2'h0, 2'h0, 4'h1, 7'h00, 8'h00, 3'h4);
    ask(2'h0, 2'h0, 4'h2, 7'h00, 8'h00, 3'h2);
    ask(2'h0, 2'h0, 4'hF, 7'h00, 8'h00, 3'h2);
    cfg_wr(`ECSC_REG_PROTO, 8'h30);
    ask(2'h0, 2'h0, 4'h0, 7'h00, 8'h00, 3'h0);
    ask(2'h0, 2'h0, 4'h1, 7'h00, 8'h00, 3'h0);
    ask(2'h0, 2'h0, 4'h2, 7'h00, 8'h00, 3'h4);
    chk8("couplerOut", 8'h01, {7'h0, couplerOut});
    ask(2'h0, 2'h0, 4'h2, 7'h00, 8'h00, 3'h4);
    chk8("couplerOut", 8'h00, {7'h0, couplerOut});
    cfg_wr(`ECSC_REG_PROTO, 8'h31);
    ask(2'h1, 2'h0, 4'h0, 7'h60, 8'h00, 3'h1);
    ask(2'h2, 2'h0, 4'h0, 7'h62, 8'h12, 3'h1);
    // Buffer fills while a frame freezes the banks, then drains once idle.
    cfg_wr(`ECSC_REG_PROTO, 8'h02);
    fork
      u_master.run_frame(8);
      begin
        wait_fa(1'b1);
        sens_wr(64'h1, 64'h2);
        sens_wr(64'h3, 64'h4);
        chk8("sensorDataReady", 8'h00, {7'h0, sensorDataReady});
        chk8("activeBank", {6'h0, expBank}, {6'h0, activeBank});
      end
    join
    wait_fa(1'b0);
    repeat (6) @(negedge mclk);
    expBank = expBank == 2'h0 ? 2'h2 : expBank - 2'h1;
    chk8("activeBank", {6'h0, expBank}, {6'h0, activeBank});
    chk8("sensorDataReady", 8'h01, {7'h0, sensorDataReady});
    reset_check();
    giveVerdict();
  end
endmodule

//--- verilog/ecsc_serial_slave.sv
`timescale 1ns/100ps
`include "ecsc_params.svh"
// Overview of operation
// (R1) Channel two carries length field plus one
// (R2) Channel two disabled means zero bits long
// (R3) Two-bit field selects channel two CRC polynomial
// (R4) Channel two CRC seeded from six-bit value
// (R5) Measure first falling to second rising edge
// (R6) Sampling period is four thirds oscillator period
// (R7) Adaptive timeout bounded by measured time plus ticks
// (R8) Slave IDs equal enabled channels plus extra
// (R9) Skip slave ID check if invalid or legacy
// (R10) Commands zero and one local unless disabled
// (R11) Command two toggles coupler port or forwards
// (R12) Addresses 0x60-0x6F hit config RAM unless protected
// (R13) Other commands and accesses go to host
// (R14) Host serves all other control register space
// (R15) Protocol select bit chooses BiSS or legacy
// (R16) Host preloads data before legacy frames start
// (R17) Bank rotation advances after each data write
// (R18) Fixed timeout bit disables adaptive timeout
// (R19) Fixed timeout is 20 us or 2 us
// (R20) Fixed timeout also allowed in BiSS mode
// (R21) Channel one optionally Gray coded, two not
// (R22) Ring mode repeats channel one, two separates
// (R23) Channel one active only while enabled
// (R24) Line output high while config invalid
// (R25) Gray bit is XOR with next higher bit
module ecsc_serial_slave #(
  parameter int CH_MAX_BITS = 64
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic lineClockIn,
  output logic lineDataOut,
  input wire logic cfgWrite,
  input wire logic [3:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  input wire logic sensorDataWriteCmd,
  output logic sensorDataReady,
  input wire logic [63:0] sensorCh1,
  input wire logic [63:0] sensorCh2,
  input wire logic ctlReq,
  input wire logic [1:0] ctlKind,
  input wire logic [1:0] ctlSlaveId,
  input wire logic [3:0] ctlCmd,
  input wire logic [6:0] ctlAddr,
  input wire logic [7:0] ctlWdata,
  output logic ctlLocal,
  output logic ctlToHost,
  output logic ctlDenied,
  output logic [7:0] ctlRdData,
  output logic couplerOut,
  output logic [1:0] activeBank,
  output logic frameActive
);
  localparam logic [11:0] TMO_LONG_CYC = 12'(`ECSC_TMO_LONG_NS / `ECSC_CLK_NS);
  localparam logic [11:0] TMO_SHORT_CYC = 12'(`ECSC_TMO_SHORT_NS / `ECSC_CLK_NS);

  // The struct and buffer are laid out for 64-bit channels only.
  if (CH_MAX_BITS != 64) begin : gBadWidth
    $error("ecsc_serial_slave supports CH_MAX_BITS of 64 only");
  end

  ecsc_pkg::ecsc_regs_s s_q, s_d;

  // Channel lengths, zero when a channel is off.
  function automatic logic [6:0] chLen(input logic [7:0] b, input logic on);
    chLen = on ? 7'({1'b0, b[5:0]}) + 7'h01 : 7'h00; // R1 R2 R23
  endfunction

  // Length of segment: 0 channel one, 1 channel two, 2 CRC.
  function automatic logic [6:0] segLen(input int sg, input logic [6:0] l1,
                                        input logic [6:0] l2, input logic [6:0] lc);
    case (sg)
      0: segLen = l1;
      1: segLen = l2;
      2: segLen = lc;
      default: segLen = 7'h00;
    endcase
  endfunction

  // First non-empty segment after cur; ring mode wraps back to channel one.
  function automatic logic [1:0] nextSeg(input int cur, input logic ring,
                                         input logic [6:0] l1, input logic [6:0] l2,
                                         input logic [6:0] lc);
    logic [1:0] r;
    r = 2'h3;
    for (int k = 2; k >= 0; k--)
    begin
      if (k > cur && segLen(k, l1, l2, lc) != 7'h00)
      begin
        r = 2'(k);
      end
    end
    if (r == 2'h3 && ring && l1 != 7'h00)
    begin
      r = 2'h0; // R22
    end
    nextSeg = r;
  endfunction

  logic [7:0] fmt1, len2b, crcb, proto;
  logic cfgValid, ch1On, ch2On, ring, clkNow, rise, fall, tick, lineHigh, accept;
  logic [6:0] len1, len2, crcLen;
  logic [15:0] poly, crcMask;
  logic [1:0] numIds;
  logic [127:0] rdWord;
  logic [11:0] limit;
  logic [1:0] ns;
  logic bitOut, fb;

  assign fmt1 = s_q.cfg[`ECSC_REG_FORMAT1];
  assign len2b = s_q.cfg[`ECSC_REG_CH2_LEN];
  assign crcb = s_q.cfg[`ECSC_REG_CH2_CRC];
  assign proto = s_q.cfg[`ECSC_REG_PROTO];
  assign cfgValid = s_q.cfg[`ECSC_REG_VALID][`ECSC_B_CFG_VALID];
  assign ch1On = fmt1[`ECSC_B_CH_EN]; // R23
  assign ch2On = ch1On && len2b[`ECSC_B_CH_EN]; // R2
  assign ring = proto[`ECSC_B_RING];
  assign len1 = chLen(fmt1, ch1On);
  assign len2 = chLen(len2b, ch2On);
  assign clkNow = s_q.clkSync[1];
  assign rise = clkNow && !s_q.clkPrev;
  assign fall = !clkNow && s_q.clkPrev;
  // Three ticks in four clocks give a sampling period of 4/3 clock periods.
  assign tick = s_q.tickPh != `ECSC_TICK_SKIP; // R6
  assign numIds = 2'(ch1On) + 2'(ch2On) + 2'(proto[`ECSC_B_EXTRA_ID]); // R8
  assign accept = !cfgValid || proto[`ECSC_B_LEGACY] || (ctlSlaveId < numIds); // R9 R15

  // CRC selection for channel two; code zero sends no CRC at all.
  assign poly = (crcb[1:0] == 2'h1) ? `ECSC_POLY5 : (crcb[1:0] == 2'h2) ? `ECSC_POLY6
              : (crcb[1:0] == 2'h3) ? `ECSC_POLY16 : 16'h0000; // R3
  assign crcLen = (crcb[1:0] == 2'h1) ? 7'h05 : (crcb[1:0] == 2'h2) ? 7'h06
                : (crcb[1:0] == 2'h3) ? 7'h10 : 7'h00;
  assign crcMask = (crcb[1:0] == 2'h1) ? 16'h001F : (crcb[1:0] == 2'h2) ? 16'h003F
                 : (crcb[1:0] == 2'h3) ? 16'hFFFF : 16'h0000;

  // Timeout limit: fixed counts in clocks or measured ticks plus a margin.
  assign limit = !proto[`ECSC_B_FIXED_TMO] ? s_q.tmoLimit // R7 R18 R20
               : proto[`ECSC_B_TMO_SHORT] ? TMO_SHORT_CYC : TMO_LONG_CYC; // R19

  // All state advances here; the frame logic only sees the synchronised clock.
  always_comb
  begin
    s_d = s_q;
    bitOut = 1'b0;
    fb = 1'b0;
    ns = 2'h3;
    rdWord = s_q.bank[s_q.readBank];
    lineHigh = 1'b1;
    s_d.clkSync = {s_q.clkSync[0], lineClockIn};
    s_d.clkPrev = clkNow;
    s_d.tickPh = s_q.tickPh + 2'h1;
    s_d.ctlLocal = 1'b0;
    s_d.ctlToHost = 1'b0;
    s_d.ctlDenied = 1'b0;

    // Host configuration writes take priority over control-frame writes.
    if (cfgWrite)
    begin
      s_d.cfg[cfgAddr] = cfgWdata;
    end

    // Control frame requests.
    if (ctlReq && accept)
    begin
      if (ctlKind == ecsc_pkg::CTL_CMD)
      begin
        if (ctlCmd <= 4'h1 && !proto[`ECSC_B_CMD01_DIS])
        begin
          s_d.ctlLocal = 1'b1; // R10
        end
        else if (ctlCmd == 4'h2 && proto[`ECSC_B_CMD2_LOCAL])
        begin
          s_d.ctlLocal = 1'b1; // R11
          s_d.coupler = !s_q.coupler;
        end
        else if (ctlCmd > 4'h1)
        begin
          s_d.ctlToHost = 1'b1; // R13
        end
      end
      else if (ctlAddr >= `ECSC_WIN_BASE && ctlAddr <= `ECSC_WIN_TOP)
      begin
        if (proto[`ECSC_B_PROTECT])
        begin
          s_d.ctlDenied = 1'b1; // R12
        end
        else
        begin
          s_d.ctlLocal = 1'b1; // R12
          s_d.ctlRdData = s_q.cfg[ctlAddr[3:0]];
          if (ctlKind == ecsc_pkg::CTL_WRITE && !cfgWrite)
          begin
            s_d.cfg[ctlAddr[3:0]] = ctlWdata;
          end
        end
      end
      else
      begin
        s_d.ctlToHost = 1'b1; // R13 R14
      end
    end

    // Sensor data buffer: filled by the host, drained only between frames.
    if (sensorDataWriteCmd && s_q.fifoCnt != 2'h2)
    begin
      s_d.fifo[s_q.fifoWr] = {sensorCh1, sensorCh2};
      s_d.fifoWr = !s_q.fifoWr;
    end
    if (s_q.fifoCnt != 2'h0 && s_q.state == ecsc_pkg::ST_IDLE)
    begin
      s_d.bank[s_q.activeBank] = s_q.fifo[s_q.fifoRd];
      s_d.fifoRd = !s_q.fifoRd;
      s_d.readBank = s_q.activeBank;
      s_d.activeBank = (s_q.activeBank == 2'h2) ? 2'h0 : s_q.activeBank + 2'h1; // R17
    end
    s_d.fifoCnt = s_q.fifoCnt + 2'(sensorDataWriteCmd && s_q.fifoCnt != 2'h2)
                  - 2'(s_q.fifoCnt != 2'h0 && s_q.state == ecsc_pkg::ST_IDLE);

    // Frame engine.
    case (s_q.state)
      ecsc_pkg::ST_IDLE:
      begin
        if (fall && cfgValid)
        begin
          s_d.snap1 = fmt1[`ECSC_B_REFLECT] ? rdWord[127:64] ^ (rdWord[127:64] >> 1)
                                             : rdWord[127:64]; // R21 R25
          s_d.snap1 = s_d.snap1 << (7'h40 - len1);
          s_d.snap2 = rdWord[63:0] << (7'h40 - len2); // R21
          s_d.sh1 = s_d.snap1;
          s_d.sh2 = s_d.snap2;
          s_d.crc = 16'({crcb[7:2]}) & crcMask; // R4
          s_d.seg = nextSeg(-1, 1'b0, len1, len2, crcLen);
          s_d.bitCnt = 7'h00;
          s_d.edgeCnt = 2'h0; // Rise, fall, rise: the capture falls on the third edge.
          s_d.measCnt = 12'h000;
          s_d.tmoCnt = 12'h000;
          s_d.tmoLimit = 12'hFFF;
          s_d.state = ecsc_pkg::ST_SEND;
        end
      end
      ecsc_pkg::ST_SEND, ecsc_pkg::ST_DONE:
      begin
        lineHigh = 1'b0;
        if (tick && s_q.edgeCnt != 2'h3 && s_q.measCnt != 12'hFFF)
        begin
          s_d.measCnt = s_q.measCnt + 12'h001; // R5
        end
        if (rise && s_q.edgeCnt == 2'h2)
        begin
          s_d.tmoLimit = s_q.measCnt + `ECSC_TMO_MARGIN; // R5 R7
        end
        if (rise || fall)
        begin
          s_d.tmoCnt = 12'h000;
          if (s_q.edgeCnt != 2'h3)
          begin
            s_d.edgeCnt = s_q.edgeCnt + 2'h1;
          end
        end
        else if ((proto[`ECSC_B_FIXED_TMO] || tick) && s_q.tmoCnt != 12'hFFF)
        begin
          s_d.tmoCnt = s_q.tmoCnt + 12'h001;
        end
        if (rise && s_q.state == ecsc_pkg::ST_SEND)
        begin
          case (s_q.seg)
            2'h0:
            begin
              bitOut = s_q.sh1[63];
              s_d.sh1 = s_q.sh1 << 1;
            end
            2'h1:
            begin
              bitOut = s_q.sh2[63];
              s_d.sh2 = s_q.sh2 << 1;
              fb = s_q.sh2[63] ^ s_q.crc[crcLen[3:0] - 4'h1];
              s_d.crc = ((s_q.crc << 1) ^ (fb ? poly : 16'h0000)) & crcMask;
            end
            2'h2:
            begin
              bitOut = s_q.crc[crcLen[3:0] - 4'h1];
              s_d.crc = (s_q.crc << 1) & crcMask;
            end
            default: bitOut = 1'b0;
          endcase
          s_d.lineOut = bitOut;
          s_d.bitCnt = s_q.bitCnt + 7'h01;
          if (s_q.bitCnt + 7'h01 >= segLen(int'(s_q.seg), len1, len2, crcLen))
          begin
            ns = nextSeg(int'(s_q.seg), ring, len1, len2, crcLen);
            s_d.seg = ns;
            s_d.bitCnt = 7'h00;
            if (ns == 2'h0)
            begin
              s_d.sh1 = s_q.snap1; // R22
              s_d.sh2 = s_q.snap2;
              s_d.crc = 16'({crcb[7:2]}) & crcMask;
            end
            else if (ns == 2'h3)
            begin
              s_d.state = ecsc_pkg::ST_DONE;
            end
          end
        end
        else if (rise)
        begin
          s_d.lineOut = 1'b0;
        end
        if (!rise && !fall && clkNow && s_q.tmoCnt >= limit)
        begin
          s_d.state = ecsc_pkg::ST_IDLE; // R7 R18
        end
      end
      default: s_d.state = ecsc_pkg::ST_IDLE;
    endcase
    if (!cfgValid || (lineHigh && s_d.state == ecsc_pkg::ST_IDLE))
    begin
      s_d.lineOut = 1'b1; // R24
    end
  end

  // One register bank for all state.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.state <= ecsc_pkg::ST_IDLE;
      s_q.lineOut <= 1'b1;
      s_q.clkSync <= 2'h3; // The line clock idles high, so no false edge follows reset.
      s_q.clkPrev <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lineDataOut = s_q.lineOut;
  assign sensorDataReady = s_q.fifoCnt != 2'h2;
  assign ctlLocal = s_q.ctlLocal;
  assign ctlToHost = s_q.ctlToHost;
  assign ctlDenied = s_q.ctlDenied;
  assign ctlRdData = s_q.ctlRdData;
  assign couplerOut = s_q.coupler;
  assign activeBank = s_q.activeBank;
  assign frameActive = s_q.state != ecsc_pkg::ST_IDLE;

  // Checks on the block's own outputs and on its buffer fill count.
  a_invalid_line_high: assert property (@(posedge mclk) disable iff (!rst_b) // R24
    !cfgValid |=> lineDataOut) else $error("line not high while config invalid");
  a_protect_denies: assert property (@(posedge mclk) disable iff (!rst_b) // R12
    ctlReq && accept && ctlKind != 2'h0 && proto[0] && ctlAddr[6:4] == 3'h6
    |=> ctlDenied && !ctlLocal) else $error("protected access not denied");
  a_other_to_host: assert property (@(posedge mclk) disable iff (!rst_b) // R13
    ctlReq && accept && ctlKind != 2'h0 && ctlAddr < 7'h60
    |=> ctlToHost) else $error("host register access not forwarded");
  a_cmd01_disabled: assert property (@(posedge mclk) disable iff (!rst_b) // R10
    ctlReq && ctlKind == 2'h0 && ctlCmd <= 4'h1 && proto[4]
    |=> !ctlLocal && !ctlToHost) else $error("disabled command executed");
  a_cmd2_toggle: assert property (@(posedge mclk) disable iff (!rst_b) // R11
    ctlReq && accept && ctlKind == 2'h0 && ctlCmd == 4'h2 && proto[5] && !cfgWrite
    |=> couplerOut != $past(couplerOut)) else $error("coupler not switched");
  a_bank_rotates: assert property (@(posedge mclk) disable iff (!rst_b) // R17
    s_q.fifoCnt != 2'h0 && !frameActive
    |=> activeBank == (($past(activeBank) == 2'h2) ? 2'h0 : $past(activeBank) + 2'h1))
    else $error("bank did not advance");
  a_fifo_no_drain: assert property (@(posedge mclk) disable iff (!rst_b)
    frameActive && !sensorDataWriteCmd |=> s_q.fifoCnt == $past(s_q.fifoCnt))
    else $error("buffer drained during frame");
  a_fixed_timeout: assert property (@(posedge mclk) disable iff (!rst_b) // R19
    frameActive && proto[1] && proto[2] && s_q.tmoCnt >= TMO_SHORT_CYC && clkNow
    && !rise |=> !frameActive) else $error("short timeout exceeded");
  a_ids_range: assert property (@(posedge mclk) disable iff (!rst_b) // R8
    ctlReq && cfgValid && !proto[6] && !fmt1[6] && !proto[3]
    |=> !ctlLocal && !ctlToHost && !ctlDenied) else $error("request taken without slave id");

  c_frame_done: cover property (@(posedge mclk) disable iff (!rst_b)
    s_q.state == ecsc_pkg::ST_DONE ##1 !frameActive);
  c_ring_wrap: cover property (@(posedge mclk) disable iff (!rst_b)
    rise && ring && s_q.seg == 2'h2 ##1 s_q.seg == 2'h0);
  c_buffer_full: cover property (@(posedge mclk) disable iff (!rst_b) !sensorDataReady);
endmodule
